// ---- rtl/dsl_pkg.sv ----
// constants and register map of the digital i/o safe/latch/counter block
// assumes an axi4-lite register bus with 32-bit data, clock at 200 MHz
package dsl_pkg;

  // channel counts
  localparam int NUM_DI = 2;
  localparam int NUM_DO = 2;

  // clocking and watchdog timing
  localparam longint CLK_HZ       = 200_000_000;
  localparam int     WDT_TICK_MS  = 100;
  localparam longint WDT_TICK_CYC = (CLK_HZ / 1000) * WDT_TICK_MS;
  localparam int     WDT_W        = 16;

  // peer mapping defaults
  localparam logic [31:0] PEER_IP_RST   = 32'hC0A8_FFC8;
  localparam logic [15:0] PEER_PORT_RST = 16'h01F6;
  localparam logic [7:0]  PEER_UNIT_RST = 8'h01;

  // safe value modes
  typedef enum logic [1:0] {
    DSL_SAFE_OFF  = 2'b00,
    DSL_SAFE_WDT  = 2'b01,
    DSL_SAFE_PEER = 2'b10
  } dsl_safe_e;

  // register byte offsets
  localparam logic [7:0] REG_DO_OUT    = 8'h00;
  localparam logic [7:0] REG_DO_PWRON  = 8'h04;
  localparam logic [7:0] REG_DO_SAFE   = 8'h08;
  localparam logic [7:0] REG_SAFE_MODE = 8'h0C;
  localparam logic [7:0] REG_WDT_TO    = 8'h10;
  localparam logic [7:0] REG_DI_CFG    = 8'h14;
  localparam logic [7:0] REG_DI_STAT   = 8'h18;
  localparam logic [7:0] REG_LATCH_CLR = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h20;
  localparam logic [7:0] REG_IRQ_CLR   = 8'h24;
  localparam logic [7:0] REG_IRQ_EN    = 8'h28;
  localparam logic [7:0] REG_PEER_IP   = 8'h2C;
  localparam logic [7:0] REG_PEER_PORT = 8'h30;
  localparam logic [7:0] REG_CNT_BASE  = 8'h40;
  localparam logic [7:0] REG_PRE_BASE  = 8'h60;

  // di_cfg field positions: latch enables low, counter enables at 8
  localparam int DI_CFG_CNT_POS = 8;

  // irq status bits
  localparam int IRQ_WDT  = 0;
  localparam int IRQ_PEER = 1;
  localparam int IRQ_CHG  = 2;
  localparam int IRQ_W    = 3;

  // reset values
  localparam logic [31:0] DO_PWRON_RST = 32'h0000_0000;
  localparam logic [31:0] DO_SAFE_RST  = 32'h0000_0000;
  localparam logic [31:0] ZERO32       = 32'h0000_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : dsl_pkg

// ---- rtl/dsl_di_chan.sv ----
// one digital input channel: change latch and 32-bit pulse counter
// assumes din is already synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module dsl_di_chan (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // input and configuration
  input  wire logic        din,
  input  wire logic        latch_en,
  input  wire logic        cnt_en,
  input  wire logic        latch_clr,
  input  wire logic        preset_ld,
  input  wire logic [31:0] preset_val,
  // state
  output logic             latched,
  output logic             changed,
  output logic [31:0]      count
);

  logic        prev_r, prev_nxt;
  logic        lat_r, lat_nxt;
  logic [31:0] cnt_r, cnt_nxt;

  // edge detect, latch and counter next values
  always_comb begin
    prev_nxt = din;
    lat_nxt  = lat_r;
    cnt_nxt  = cnt_r;
    changed  = (din != prev_r);
    if (!latch_en) begin
      lat_nxt = din;                       // transparent when disabled
    end else if (changed) begin
      lat_nxt = 1'b1;                      // set wins over clear
    end else if (latch_clr) begin
      lat_nxt = din;
    end
    if (preset_ld) begin
      cnt_nxt = preset_val;
    end else if (cnt_en && din && !prev_r) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
      lat_r  <= 1'b0;
      cnt_r  <= dsl_pkg::ZERO32;
    end else begin
      prev_r <= prev_nxt;
      lat_r  <= lat_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign latched = lat_r;
  assign count   = cnt_r;

endmodule : dsl_di_chan
`default_nettype wire

// ---- rtl/dsl_top.sv ----
// digital i/o block: outputs with power-on/safe values, inputs with
// change latch and counters, axi4-lite register slave, interrupt
// assumes din and peer_fail synchronous to aclk; host_activity pulses
// once per host transaction seen by the network side
//
// Summary of operation
// - safe value disabled: outputs keep present state on any failure
// - watchdog enabled when timeout non-zero, disabled at zero
// - timeout is 16-bit count in 0.1 s steps, zero disables
// - watchdog mode: outputs go safe after host silence for timeout
// - peer mode: outputs go safe when peer exchange fails
// - after reset each output takes its power-on value
// - latch enabled: any input change held until host clears
// - each input has 32-bit counter read as low and high words
// - counter mode: count increments once per input pulse
// - per-channel preset value loaded as counter start
// - peer defaults: 192.168.255.200, port 502, unit 1
`timescale 1ns/1ps
`default_nettype none
module dsl_top (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // axi4-lite write address
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // digital pins
  input  wire logic [dsl_pkg::NUM_DI-1:0] din,
  output logic      [dsl_pkg::NUM_DO-1:0] dout,
  // link status from network side
  input  wire logic                       host_activity,
  input  wire logic                       peer_fail,
  // interrupt
  output logic                            irq
);

  localparam int ND = dsl_pkg::NUM_DI;
  localparam int NO = dsl_pkg::NUM_DO;
  typedef dsl_pkg::dsl_safe_e dsl_safe_e;

  ////////////////////////////////////////////////////////////////////
  // register state
  logic [NO-1:0]  do_r, do_nxt;
  logic [NO-1:0]  pwron_r, pwron_nxt;
  logic [NO-1:0]  safe_r, safe_nxt;
  logic [1:0]     mode_r, mode_nxt;
  logic [15:0]    wdt_to_r, wdt_to_nxt;
  logic [ND-1:0]  lat_en_r, lat_en_nxt;
  logic [ND-1:0]  cnt_en_r, cnt_en_nxt;
  logic [31:0]    preset_r [ND];
  logic [31:0]    preset_nxt [ND];
  logic [31:0]    peer_ip_r, peer_ip_nxt;
  logic [31:0]    peer_port_r, peer_port_nxt;
  localparam int IRQ_W_L = dsl_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] ist_r, ist_nxt;
  logic [IRQ_W_L-1:0] ien_r, ien_nxt;

  // bus state
  logic        awv_r, awv_nxt, wv_r, wv_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic        bv_r, bv_nxt, rv_r, rv_nxt, arr_r, arr_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0] rd_r, rd_nxt;

  // watchdog state
  logic [31:0] tick_r, tick_nxt;
  logic [15:0] wcnt_r, wcnt_nxt;
  logic        wexp_r, wexp_nxt;
  logic        peer_prev_r, peer_prev_nxt;
  logic        irq_r, irq_nxt;

  // per-channel wires
  logic [ND-1:0] ch_lat, ch_chg, lat_clr, pre_ld;
  logic [31:0]   ch_cnt [ND];

  ////////////////////////////////////////////////////////////////////
  // input channels
  genvar g;
  generate
    for (g = 0; g < ND; g++) begin : g_di
      dsl_di_chan u_ch (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .din        (din[g]),
        .latch_en   (lat_en_r[g]),
        .cnt_en     (cnt_en_r[g]),
        .latch_clr  (lat_clr[g]),
        .preset_ld  (pre_ld[g]),
        .preset_val (preset_nxt[g]),
        .latched    (ch_lat[g]),
        .changed    (ch_chg[g]),
        .count      (ch_cnt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // write channel: accept aw and w in any order, one write at a time
  logic       wr_go;
  logic [7:0] wa;
  logic [5:0] widx;
  assign wr_go = awv_r && wv_r && !bv_r;
  assign wa    = awa_r;
  assign widx  = wa[7:2];

  function automatic logic [31:0] strb(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : strb

  logic wr_hit;
  logic [31:0] m;

  // register file and write handshake next values
  always_comb begin
    awv_nxt = awv_r;
    awa_nxt = awa_r;
    wv_nxt  = wv_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    bv_nxt  = bv_r;
    br_nxt  = br_r;
    do_nxt  = do_r;
    pwron_nxt = pwron_r;
    safe_nxt  = safe_r;
    mode_nxt  = mode_r;
    wdt_to_nxt = wdt_to_r;
    lat_en_nxt = lat_en_r;
    cnt_en_nxt = cnt_en_r;
    peer_ip_nxt = peer_ip_r;
    peer_port_nxt = peer_port_r;
    ien_nxt = ien_r;
    lat_clr = '0;
    pre_ld  = '0;
    wr_hit  = 1'b1;
    m       = dsl_pkg::ZERO32;
    for (int i = 0; i < ND; i++) begin
      preset_nxt[i] = preset_r[i];
    end
    if (s_axi_awvalid && !awv_r) begin
      awv_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wv_r) begin
      wv_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (wr_go) begin
      awv_nxt = 1'b0;
      wv_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      case (wa)
        dsl_pkg::REG_DO_OUT: begin
          m = strb({{(32-NO){1'b0}}, do_r}, wd_r, ws_r);
          do_nxt = m[NO-1:0];
        end
        dsl_pkg::REG_DO_PWRON: begin
          m = strb({{(32-NO){1'b0}}, pwron_r}, wd_r, ws_r);
          pwron_nxt = m[NO-1:0];
        end
        dsl_pkg::REG_DO_SAFE: begin
          m = strb({{(32-NO){1'b0}}, safe_r}, wd_r, ws_r);
          safe_nxt = m[NO-1:0];
        end
        dsl_pkg::REG_SAFE_MODE: begin
          m = strb({30'h0000_0000, mode_r}, wd_r, ws_r);
          mode_nxt = m[1:0];
        end
        dsl_pkg::REG_WDT_TO: begin
          m = strb({16'h0000, wdt_to_r}, wd_r, ws_r);
          wdt_to_nxt = m[15:0];
        end
        dsl_pkg::REG_DI_CFG: begin
          m = strb({{(24-ND){1'b0}}, cnt_en_r,
                    {(8-ND){1'b0}}, lat_en_r}, wd_r, ws_r);
          lat_en_nxt = m[ND-1:0];
          cnt_en_nxt = m[dsl_pkg::DI_CFG_CNT_POS +: ND];
        end
        dsl_pkg::REG_LATCH_CLR: lat_clr = wd_r[ND-1:0];
        dsl_pkg::REG_IRQ_EN: begin
          m = strb({{(32-IRQ_W_L){1'b0}}, ien_r}, wd_r, ws_r);
          ien_nxt = m[IRQ_W_L-1:0];
        end
        dsl_pkg::REG_IRQ_CLR: ;
        dsl_pkg::REG_PEER_IP: peer_ip_nxt = strb(peer_ip_r, wd_r, ws_r);
        dsl_pkg::REG_PEER_PORT:
          peer_port_nxt = strb(peer_port_r, wd_r, ws_r);
        default: begin
          wr_hit = 1'b0;
          for (int i = 0; i < ND; i++) begin
            if (widx == 6'((dsl_pkg::REG_PRE_BASE >> 2) + i)) begin
              preset_nxt[i] = strb(preset_r[i], wd_r, ws_r);
              pre_ld[i] = 1'b1;
              wr_hit = 1'b1;
            end
          end
        end
      endcase
      br_nxt = wr_hit ? dsl_pkg::RESP_OKAY : dsl_pkg::RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read channel: one cycle from arvalid to rvalid
  always_comb begin
    rv_nxt  = rv_r;
    rd_nxt  = rd_r;
    rr_nxt  = rr_r;
    arr_nxt = 1'b0;
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rv_r && !arr_r) begin
      arr_nxt = 1'b1;
      rv_nxt  = 1'b1;
      rr_nxt  = dsl_pkg::RESP_OKAY;
      rd_nxt  = dsl_pkg::ZERO32;
      case (s_axi_araddr)
        dsl_pkg::REG_DO_OUT:    rd_nxt[NO-1:0] = dout;
        dsl_pkg::REG_DO_PWRON:  rd_nxt[NO-1:0] = pwron_r;
        dsl_pkg::REG_DO_SAFE:   rd_nxt[NO-1:0] = safe_r;
        dsl_pkg::REG_SAFE_MODE: rd_nxt[1:0] = mode_r;
        dsl_pkg::REG_WDT_TO:    rd_nxt[15:0] = wdt_to_r;
        dsl_pkg::REG_DI_CFG: begin
          rd_nxt[ND-1:0] = lat_en_r;
          rd_nxt[dsl_pkg::DI_CFG_CNT_POS +: ND] = cnt_en_r;
        end
        dsl_pkg::REG_DI_STAT: begin
          rd_nxt[ND-1:0] = ch_lat;
          rd_nxt[16 +: ND] = din;
        end
        dsl_pkg::REG_LATCH_CLR: ;
        dsl_pkg::REG_IRQ_STAT:  rd_nxt[IRQ_W_L-1:0] = ist_r;
        dsl_pkg::REG_IRQ_CLR:   ;
        dsl_pkg::REG_IRQ_EN:    rd_nxt[IRQ_W_L-1:0] = ien_r;
        dsl_pkg::REG_PEER_IP:   rd_nxt = peer_ip_r;
        dsl_pkg::REG_PEER_PORT: rd_nxt = peer_port_r;
        default: begin
          rr_nxt = dsl_pkg::RESP_SLVERR;
          for (int i = 0; i < ND; i++) begin
            // low word then high word, two addresses per channel
            if (s_axi_araddr[7:2] ==
                6'((dsl_pkg::REG_CNT_BASE >> 2) + 2*i)) begin
              rd_nxt = {16'h0000, ch_cnt[i][15:0]};
              rr_nxt = dsl_pkg::RESP_OKAY;
            end
            if (s_axi_araddr[7:2] ==
                6'((dsl_pkg::REG_CNT_BASE >> 2) + 2*i + 1)) begin
              rd_nxt = {16'h0000, ch_cnt[i][31:16]};
              rr_nxt = dsl_pkg::RESP_OKAY;
            end
            if (s_axi_araddr[7:2] ==
                6'((dsl_pkg::REG_PRE_BASE >> 2) + i)) begin
              rd_nxt = preset_r[i];
              rr_nxt = dsl_pkg::RESP_OKAY;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // host watchdog: counts 0.1 s ticks of host silence
  logic wdt_on;
  assign wdt_on = (wdt_to_r != 16'h0000);
  logic peer_rise;
  assign peer_rise = peer_fail && !peer_prev_r;
  logic [NO-1:0] dout_nxt;

  always_comb begin
    tick_nxt = tick_r;
    wcnt_nxt = wcnt_r;
    wexp_nxt = wexp_r;
    peer_prev_nxt = peer_fail;
    if (!wdt_on || host_activity) begin
      tick_nxt = dsl_pkg::ZERO32;
      wcnt_nxt = 16'h0000;
      wexp_nxt = 1'b0;
    end else if (!wexp_r) begin
      if (tick_r == 32'(dsl_pkg::WDT_TICK_CYC - 1)) begin
        tick_nxt = dsl_pkg::ZERO32;
        wcnt_nxt = wcnt_r + 16'h0001;
        if (wcnt_r + 16'h0001 == wdt_to_r) begin
          wexp_nxt = 1'b1;
        end
      end else begin
        tick_nxt = tick_r + 32'h0000_0001;
      end
    end
    // output selection: host write, else safe value on failure
    dout_nxt = do_nxt;
    case (dsl_safe_e'(mode_r))
      dsl_pkg::DSL_SAFE_WDT:
        if (wexp_nxt) dout_nxt = safe_r;
      dsl_pkg::DSL_SAFE_PEER:
        if (peer_fail) dout_nxt = safe_r;
      default: ;
    endcase
    // sticky status: set wins over the clear of the same cycle
    ist_nxt = ist_r;
    if (wr_go && wa == dsl_pkg::REG_IRQ_CLR) begin
      ist_nxt = ist_r & ~wd_r[IRQ_W_L-1:0];
    end
    if (wexp_nxt && !wexp_r) ist_nxt[dsl_pkg::IRQ_WDT] = 1'b1;
    if (peer_rise) ist_nxt[dsl_pkg::IRQ_PEER] = 1'b1;
    if (|(ch_chg & lat_en_r)) ist_nxt[dsl_pkg::IRQ_CHG] = 1'b1;
    irq_nxt = |(ist_nxt & ien_r);
  end

  logic [NO-1:0] dout_r;
  logic dwr_seen_r;

  ////////////////////////////////////////////////////////////////////
  // state registers except dwr_seen_r and those inside the input channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      do_r      <= dsl_pkg::DO_PWRON_RST[NO-1:0];
      dout_r    <= dsl_pkg::DO_PWRON_RST[NO-1:0];
      pwron_r   <= dsl_pkg::DO_PWRON_RST[NO-1:0];
      safe_r    <= dsl_pkg::DO_SAFE_RST[NO-1:0];
      mode_r    <= 2'b00;
      wdt_to_r  <= 16'h0000;
      lat_en_r  <= '0;
      cnt_en_r  <= '0;
      peer_ip_r   <= dsl_pkg::PEER_IP_RST;
      peer_port_r <= {8'h00, dsl_pkg::PEER_UNIT_RST,
                      dsl_pkg::PEER_PORT_RST};
      ist_r <= '0;
      ien_r <= '0;
      irq_r <= 1'b0;
      awv_r <= 1'b0;
      awa_r <= 8'h00;
      wv_r  <= 1'b0;
      wd_r  <= dsl_pkg::ZERO32;
      ws_r  <= 4'h0;
      bv_r  <= 1'b0;
      br_r  <= 2'b00;
      rv_r  <= 1'b0;
      rr_r  <= 2'b00;
      rd_r  <= dsl_pkg::ZERO32;
      arr_r <= 1'b0;
      tick_r <= dsl_pkg::ZERO32;
      wcnt_r <= 16'h0000;
      wexp_r <= 1'b0;
      peer_prev_r <= 1'b0;
      for (int i = 0; i < ND; i++) preset_r[i] <= dsl_pkg::ZERO32;
    end else begin
      // power-on value follows its register until the host's first direct output write
      do_r      <= (wr_go && wa == dsl_pkg::REG_DO_PWRON && !dwr_seen_r)
                   ? pwron_nxt : do_nxt;
      dout_r    <= (wr_go && wa == dsl_pkg::REG_DO_PWRON && !dwr_seen_r)
                   ? pwron_nxt : dout_nxt;
      pwron_r   <= pwron_nxt;
      safe_r    <= safe_nxt;
      mode_r    <= mode_nxt;
      wdt_to_r  <= wdt_to_nxt;
      lat_en_r  <= lat_en_nxt;
      cnt_en_r  <= cnt_en_nxt;
      peer_ip_r   <= peer_ip_nxt;
      peer_port_r <= peer_port_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
      awv_r <= awv_nxt;
      awa_r <= awa_nxt;
      wv_r  <= wv_nxt;
      wd_r  <= wd_nxt;
      ws_r  <= ws_nxt;
      bv_r  <= bv_nxt;
      br_r  <= br_nxt;
      rv_r  <= rv_nxt;
      rr_r  <= rr_nxt;
      rd_r  <= rd_nxt;
      arr_r <= arr_nxt;
      tick_r <= tick_nxt;
      wcnt_r <= wcnt_nxt;
      wexp_r <= wexp_nxt;
      peer_prev_r <= peer_prev_nxt;
      for (int i = 0; i < ND; i++) preset_r[i] <= preset_nxt[i];
    end
  end

  // marks first direct output write; power-on edits stop acting after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dwr_seen_r <= 1'b0;
    end else if (wr_go && wa == dsl_pkg::REG_DO_OUT) begin
      dwr_seen_r <= 1'b1;
    end
  end

  // outputs from flip-flops, except awready and wready, which are combinational
  assign dout          = dout_r;
  assign irq           = irq_r;
  assign s_axi_awready = s_axi_awvalid && !awv_r;
  assign s_axi_wready  = s_axi_wvalid && !wv_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;

endmodule : dsl_top
`default_nettype wire

// ---- dv/dsl_props.sv ----
// concurrent checks on the ports of dsl_top
// assumes one clock domain, aclk with sync active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module dsl_props (
  // clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // axi4-lite
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  // pins
  input wire logic [dsl_pkg::NUM_DO-1:0] dout,
  input wire logic                       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // reset check runs through reset, so it overrides the disable
  a_rst_state: assert property (disable iff (1'b0)
    !aresetn |=> dout == 2'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state not at reset values");
  // ready is only offered to a request that is present
  a_aw_cause: assert property (s_axi_awready |-> s_axi_awvalid ##1
    !s_axi_awready)
    else $error("awready without awvalid or held");
  a_w_cause: assert property (s_axi_wready |-> s_axi_wvalid ##1
    !s_axi_wready)
    else $error("wready without wvalid or held");
  // one transfer at a time: an accepted answer is not repeated
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  // read answer one cycle after a fresh request
  a_r_latency: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  a_b_code: assert property (s_axi_bvalid |->
    s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("illegal write response");
  // refused reads return zero data
  a_r_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");
endmodule : dsl_props
bind dsl_top dsl_props i_dsl_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dout, .irq);
`default_nettype wire

// ---- dv/dsl_peer.sv ----
// model of the network side: peer exchange status and host traffic
// assumes requests from the bench, registered on aclk
`timescale 1ns/1ps
`default_nettype none
module dsl_peer (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // bench commands
  input  wire logic fail_req,
  input  wire logic ping_req,
  // status toward the block
  output logic      peer_fail,
  output logic      host_activity
);
  logic ping_q;
  // failure is a level for as long as the exchange is broken
  always_ff @(posedge aclk) begin
    ping_q        <= aresetn & ping_req;
    peer_fail     <= aresetn & fail_req;
    host_activity <= aresetn & ping_req & ~ping_q; // one pulse per request
  end
endmodule : dsl_peer
`default_nettype wire

// ---- dv/dsl_top_tb.sv ----
// self-checking bench of dsl_top over axi4-lite, pins and peer model
// assumes dsl_pkg register map and one-cycle read answer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  fails++; $display("unexpected at %0t: got %h want %h", $time, a, e); \
  end end
module dsl_top_tb;
  logic        aclk, aresetn, fail_req, ping_req, peer_fail;
  logic        host_activity, irq, s_axi_awready, s_axi_wready;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_bvalid;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [dsl_pkg::NUM_DI-1:0] din;
  logic [dsl_pkg::NUM_DO-1:0] dout;
  int          fails = 0, samples_checked = 0, cycles = 0;
  dsl_top i_dsl_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .din, .dout,
    .host_activity, .peer_fail, .irq);
  dsl_peer i_dsl_peer (.aclk, .aresetn, .fail_req, .ping_req, .peer_fail,
    .host_activity);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic complete_run;
    $display("checked %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // handshakes judged at negedge, so no race with the design's edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic aw_go, w_go, b_go;
    logic [1:0] resp;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go  = s_axi_wvalid && s_axi_wready;
      b_go  = s_axi_bvalid;
      resp  = s_axi_bresp;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
    end while (!b_go);
    `CHK(resp, er)
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar_go, r_go;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ar_go = s_axi_arready;
      r_go  = s_axi_rvalid;
      d     = s_axi_rdata;
      r     = s_axi_rresp;
      @(posedge aclk);
      if (ar_go) s_axi_arvalid <= 1'b0;
    end while (!r_go);
    @(posedge aclk); // idle edge: a next read never reuses this one
  endtask : rd
  task automatic rck(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, 2'h0)
  endtask : rck
  // wait bounded for a pin value, sampled away from the edge
  task automatic pin_chk(input logic [1:0] e, input logic i);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((dout !== e || irq !== i) && n < 20);
    `CHK({dout, irq}, {e, i})
    @(posedge aclk);
  endtask : pin_chk
  task automatic do_reset;
    aresetn <= 1'b0;
    cyc(10);
    aresetn <= 1'b1;
    pin_chk(2'h0, 1'b0);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // hang guard, far above the fewer than two hundred cycles of the run
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  initial begin : main
    logic [31:0] d, v, s;
    logic [1:0]  r;
    {fail_req, ping_req, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata, din} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    s = lfsr(32'h1bb2_35fc);
    do_reset();
    rck(dsl_pkg::REG_PEER_IP, 32'hc0a8_ffc8);
    rck(dsl_pkg::REG_PEER_PORT, 32'h0001_01f6);
    rck(dsl_pkg::REG_WDT_TO, 32'h0000_0000);
    wr(dsl_pkg::REG_WDT_TO, 32'habcd_ffff);
    rck(dsl_pkg::REG_WDT_TO, 32'h0000_ffff);
    wr(dsl_pkg::REG_WDT_TO, 32'h0000_0000);
    wr(8'hfc, 32'h1234_5678, 2'h2);
    rd(8'hfc, d, r);
    `CHK({r, d}, {2'h2, 32'h0000_0000})
    wr(dsl_pkg::REG_DO_PWRON, 32'h0000_0002);
    pin_chk(2'h2, 1'b0);
    // random outputs, safe value is their inverse
    wr(dsl_pkg::REG_DO_OUT, {30'h0, s[1:0]});
    wr(dsl_pkg::REG_DO_SAFE, {30'h0, ~s[1:0]});
    fail_req <= 1'b1;
    cyc(8);
    pin_chk(s[1:0], 1'b0);
    wr(dsl_pkg::REG_SAFE_MODE, 32'h0000_0001);
    ping_req <= 1'b1;
    cyc(8);
    pin_chk(s[1:0], 1'b0);
    ping_req <= 1'b0;
    wr(dsl_pkg::REG_SAFE_MODE, 32'h0000_0002);
    pin_chk(~s[1:0], 1'b0);
    wr(dsl_pkg::REG_IRQ_EN, 32'h0000_0002);
    pin_chk(~s[1:0], 1'b1);
    rck(dsl_pkg::REG_IRQ_STAT, 32'h0000_0002);
    wr(dsl_pkg::REG_IRQ_CLR, 32'h0000_0002);
    pin_chk(~s[1:0], 1'b0);
    fail_req <= 1'b0;
    pin_chk(s[1:0], 1'b0);
    // latch on input 0, counter on input 1 across a low-word carry
    wr(dsl_pkg::REG_DI_CFG, 32'h0000_0201);
    v = 32'h0000_fffe;
    wr(dsl_pkg::REG_PRE_BASE + 8'h04, v);
    rck(dsl_pkg::REG_CNT_BASE + 8'h08, {16'h0000, v[15:0]});
    repeat (2 + s[4:2]) begin
      din <= 2'h3;
      cyc(1);
      din <= 2'h0;
      cyc(1);
      v = v + 32'h0000_0001;
    end
    rck(dsl_pkg::REG_CNT_BASE + 8'h08, {16'h0000, v[15:0]});
    rck(dsl_pkg::REG_CNT_BASE + 8'h0c, {16'h0000, v[31:16]});
    rck(dsl_pkg::REG_DI_STAT, 32'h0000_0001);
    wr(dsl_pkg::REG_LATCH_CLR, 32'h0000_0001);
    rck(dsl_pkg::REG_DI_STAT, 32'h0000_0000);
    do_reset();
    complete_run();
  end
endmodule : dsl_top_tb
`default_nettype wire
